// ===== verilog/core_regs_pkg.sv
// Shared constants for the core register stack and its helpers.
package core_regs_pkg;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned ADDR_W    = 6;
	localparam int unsigned NUM_GPR   = 13;
	localparam int unsigned INTERRUPT_STATUS_FIELD_W    = 9;
	localparam int unsigned BASE_PRIORITY_MASK_REG_W = 8;
	localparam int unsigned LIM_LOW   = 3;
	localparam int unsigned LIM_W     = DATA_W - LIM_LOW;
	localparam logic [5:0] IDX_SP        = 6'h0D;
	localparam logic [5:0] IDX_LR        = 6'h0E;
	localparam logic [5:0] IDX_PC        = 6'h0F;
	localparam logic [5:0] IDX_COMBINED_STATUS_WORD      = 6'h10;
	localparam logic [5:0] IDX_APPLICATION_FLAG_FIELD      = 6'h11;
	localparam logic [5:0] IDX_INTERRUPT_STATUS_FIELD      = 6'h12;
	localparam logic [5:0] IDX_EXECUTION_STATUS_FIELD      = 6'h13;
	localparam logic [5:0] IDX_MSP       = 6'h14;
	localparam logic [5:0] IDX_PSP       = 6'h15;
	localparam logic [5:0] IDX_PRIORITY_MASK_REG   = 6'h16;
	localparam logic [5:0] IDX_FAULT_MASK_REG = 6'h17;
	localparam logic [5:0] IDX_BASE_PRIORITY_MASK_REG   = 6'h18;
	localparam logic [5:0] IDX_CONTROL   = 6'h19;
	localparam logic [5:0] IDX_MAIN_STACK_LIMIT    = 6'h1A;
	localparam logic [5:0] IDX_PROCESS_STACK_LIMIT    = 6'h1B;
	localparam int unsigned NS_ALIAS_BIT = 5;
	localparam int unsigned CTRL_NPRIV   = 0;
	localparam int unsigned CTRL_STACK_SELECT_BIT   = 1;
	localparam int unsigned TBIT_POS     = 24;
	localparam logic [31:0] APPLICATION_FLAG_FIELD_MASK    = 32'hF80F0000;
	localparam logic [31:0] LR_RST       = 32'hFFFFFFFF;
	localparam logic [31:0] PUSH_STEP    = 32'h00000004;
	localparam logic        BANK_NS      = 1'b0;
	localparam logic        BANK_S       = 1'b1;
	typedef enum logic [0:0] {
		PH_FETCH = 1'b0,
		PH_RUN   = 1'b1
	} phase_t;
endpackage : core_regs_pkg

// ===== verilog/stack_ptr_select.sv
// Combinational choice of the active stack pointer and its limit.
`timescale 1ns/1ps
`default_nettype none
module stack_ptr_select
	import core_regs_pkg::*;
(
	// Execution context
	input  wire logic                         handler,
	input  wire logic                         bank,
	input  wire logic [1:0]                   spselBank,
	// Banked pointers and limits
	input  wire logic [1:0][DATA_W-1:0]       mspBank,
	input  wire logic [1:0][DATA_W-1:0]       pspBank,
	input  wire logic [1:0][LIM_W-1:0]        mspLimBank,
	input  wire logic [1:0][LIM_W-1:0]        pspLimBank,
	// Selection
	output logic                              useProc,
	output logic      [DATA_W-1:0]            activeSp,
	output logic      [DATA_W-1:0]            activeLim
);
	always_comb begin
		useProc   = !handler && spselBank[bank];
		activeSp  = useProc ? pspBank[bank] : mspBank[bank];
		activeLim = useProc ? {pspLimBank[bank], 3'h0} : {mspLimBank[bank], 3'h0};
	end
endmodule : stack_ptr_select
`default_nettype wire

// ===== verilog/reg_access_decode.sv
// Decodes a register index into legality and access class.
`timescale 1ns/1ps
`default_nettype none
module reg_access_decode
	import core_regs_pkg::*;
(
	// Access
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              privileged,
	input  wire logic              secure,
	input  wire logic              secExt,
	// Decode
	output logic      [ADDR_W-1:0] baseIdx,
	output logic                   nsAlias,
	output logic                   readOnly,
	output logic                   denied
);
	function automatic logic isBanked(input logic [5:0] idx);
		return idx >= IDX_MSP && idx <= IDX_PROCESS_STACK_LIMIT;
	endfunction : isBanked

	function automatic logic isPrivOnly(input logic [5:0] idx);
		return idx == IDX_INTERRUPT_STATUS_FIELD || idx == IDX_EXECUTION_STATUS_FIELD || (idx >= IDX_PRIORITY_MASK_REG && idx <= IDX_PROCESS_STACK_LIMIT);
	endfunction : isPrivOnly

	logic known;

	always_comb begin
		baseIdx  = {1'b0, addr[NS_ALIAS_BIT-1:0]};
		nsAlias  = addr[NS_ALIAS_BIT];
		known    = nsAlias ? isBanked(baseIdx) : (addr <= IDX_PROCESS_STACK_LIMIT);
		readOnly = baseIdx == IDX_INTERRUPT_STATUS_FIELD || baseIdx == IDX_EXECUTION_STATUS_FIELD;
		denied   = !known || (isPrivOnly(baseIdx) && !privileged)
			|| (nsAlias && !(secExt && secure));
	end
endmodule : reg_access_decode
`default_nettype wire

// ===== verilog/core_register_stack_select.sv
// Core register file with banked stack pointers, push and limit checking.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module core_register_stack_select
	import core_regs_pkg::*;
#(
	parameter bit SEC_EXT = 1'b1
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	// Execution context
	input  wire logic              secureIn,
	input  wire logic [INTERRUPT_STATUS_FIELD_W-1:0] excNum,
	// Reset vector
	input  wire logic              vecValid,
	input  wire logic [DATA_W-1:0] vecSp,
	input  wire logic [DATA_W-1:0] vecPc,
	output logic                   vecFetch,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdData,
	// Push request and memory write
	input  wire logic              pushReq,
	input  wire logic [DATA_W-1:0] pushItem,
	output logic                   memWr,
	output logic      [DATA_W-1:0] memAddr,
	output logic      [DATA_W-1:0] memData,
	// Status
	output logic                   stackFault,
	output logic                   accessFault,
	output logic                   thumbBit
);
	typedef struct packed {
		phase_t                           phase;
		logic [NUM_GPR-1:0][DATA_W-1:0]   gpr;
		logic [1:0][DATA_W-1:0]           main_stack_ptr;
		logic [1:0][DATA_W-1:0]           process_stack_ptr;
		logic [1:0][LIM_W-1:0]            main_stack_limit;
		logic [1:0][LIM_W-1:0]            process_stack_limit;
		logic [1:0]                       priority_mask_reg;
		logic [1:0]                       fault_mask_reg;
		logic [1:0][BASE_PRIORITY_MASK_REG_W-1:0]        base_priority_mask_reg;
		logic [1:0][1:0]                  control;
		logic [DATA_W-1:0]                lr;
		logic [DATA_W-1:0]                pc;
		logic [DATA_W-1:0]                application_flag_field;
		logic [INTERRUPT_STATUS_FIELD_W-1:0]                interrupt_status_field;
		logic                             tBit;
		logic [DATA_W-1:0]                rdData;
		logic                             memWr;
		logic [DATA_W-1:0]                memAddr;
		logic [DATA_W-1:0]                memData;
		logic                             stackFault;
		logic                             accessFault;
		logic                             vecFetch;
	} state_t;

	state_t            cur_ff;
	state_t            nxt_state;
	logic              curBank;
	logic              handler;
	logic              privileged;
	logic              useProc;
	logic [DATA_W-1:0] activeSp;
	logic [DATA_W-1:0] activeLim;
	logic [DATA_W-1:0] pushSp;
	logic [ADDR_W-1:0] baseIdx;
	logic              nsAlias;
	logic              readOnly;
	logic              denied;
	logic              tgtBank;
	logic [DATA_W-1:0] rdVal;
	logic [1:0]        spselBank;

	// Without the extension everything lives in a single bank.
	assign curBank    = SEC_EXT ? secureIn : BANK_S;
	assign handler    = cur_ff.interrupt_status_field != '0;
	assign privileged = handler || !cur_ff.control[curBank][CTRL_NPRIV];
	assign tgtBank    = nsAlias ? BANK_NS : curBank;
	assign pushSp     = activeSp - PUSH_STEP;
	assign spselBank  = {cur_ff.control[1][CTRL_STACK_SELECT_BIT], cur_ff.control[0][CTRL_STACK_SELECT_BIT]};

	stack_ptr_select u_sel (
		.handler    (handler),
		.bank       (curBank),
		.spselBank  (spselBank),
		.mspBank    (cur_ff.main_stack_ptr),
		.pspBank    (cur_ff.process_stack_ptr),
		.mspLimBank (cur_ff.main_stack_limit),
		.pspLimBank (cur_ff.process_stack_limit),
		.useProc    (useProc),
		.activeSp   (activeSp),
		.activeLim  (activeLim)
	);

	reg_access_decode u_dec (
		.addr       (regAddr),
		.privileged (privileged),
		.secure     (secureIn),
		.secExt     (SEC_EXT),
		.baseIdx    (baseIdx),
		.nsAlias    (nsAlias),
		.readOnly   (readOnly),
		.denied     (denied)
	);

	// Read value for the addressed register; execution bits read as zero.
	always_comb begin
		rdVal = '0;
		if (regAddr < IDX_SP) begin
			rdVal = cur_ff.gpr[regAddr[3:0]];
		end else begin
			unique case (baseIdx)
				IDX_SP:        rdVal = activeSp;
				IDX_LR:        rdVal = cur_ff.lr;
				IDX_PC:        rdVal = cur_ff.pc;
				IDX_COMBINED_STATUS_WORD:      rdVal = cur_ff.application_flag_field | {23'h0, cur_ff.interrupt_status_field};
				IDX_APPLICATION_FLAG_FIELD:      rdVal = cur_ff.application_flag_field;
				IDX_INTERRUPT_STATUS_FIELD:      rdVal = {23'h0, cur_ff.interrupt_status_field};
				IDX_MSP:       rdVal = cur_ff.main_stack_ptr[tgtBank];
				IDX_PSP:       rdVal = cur_ff.process_stack_ptr[tgtBank];
				IDX_PRIORITY_MASK_REG:   rdVal = {31'h0, cur_ff.priority_mask_reg[tgtBank]};
				IDX_FAULT_MASK_REG: rdVal = {31'h0, cur_ff.fault_mask_reg[tgtBank]};
				IDX_BASE_PRIORITY_MASK_REG:   rdVal = {24'h0, cur_ff.base_priority_mask_reg[tgtBank]};
				IDX_CONTROL:   rdVal = {30'h0, cur_ff.control[tgtBank]};
				IDX_MAIN_STACK_LIMIT:    rdVal = {cur_ff.main_stack_limit[tgtBank], 3'h0};
				IDX_PROCESS_STACK_LIMIT:    rdVal = {cur_ff.process_stack_limit[tgtBank], 3'h0};
				default:       rdVal = '0;
			endcase
		end
	end

	always_comb begin
		nxt_state             = cur_ff;
		nxt_state.rdData      = '0;
		nxt_state.memWr       = 1'b0;
		nxt_state.stackFault  = 1'b0;
		nxt_state.accessFault = 1'b0;
		nxt_state.interrupt_status_field        = excNum;
		unique case (cur_ff.phase)
			PH_FETCH: begin
				nxt_state.vecFetch = 1'b1;
				if (vecValid) begin
					nxt_state.main_stack_ptr[BANK_S] = vecSp;
					nxt_state.pc          = {vecPc[31:1], 1'b0};
					nxt_state.tBit        = vecPc[0];
					nxt_state.vecFetch    = 1'b0;
					nxt_state.phase       = PH_RUN;
				end
			end
			PH_RUN: begin
				if (regRd) begin
					if (denied) begin
						nxt_state.accessFault = 1'b1;
					end else begin
						nxt_state.rdData = rdVal;
					end
				end
				if (regWr) begin
					if (denied || readOnly) begin
						nxt_state.accessFault = 1'b1;
					end else if (regAddr < IDX_SP) begin
						nxt_state.gpr[regAddr[3:0]] = regWrData;
					end else begin
						unique case (baseIdx)
							IDX_SP: begin
								if (regWrData < activeLim) begin
									nxt_state.stackFault = 1'b1;
								end else if (useProc) begin
									nxt_state.process_stack_ptr[curBank] = regWrData;
								end else begin
									nxt_state.main_stack_ptr[curBank] = regWrData;
								end
							end
							IDX_LR:        nxt_state.lr = regWrData;
							IDX_PC:        nxt_state.pc = regWrData;
							IDX_COMBINED_STATUS_WORD, IDX_APPLICATION_FLAG_FIELD: nxt_state.application_flag_field = regWrData & APPLICATION_FLAG_FIELD_MASK;
							IDX_MSP:       nxt_state.main_stack_ptr[tgtBank] = regWrData;
							IDX_PSP:       nxt_state.process_stack_ptr[tgtBank] = regWrData;
							IDX_PRIORITY_MASK_REG:   nxt_state.priority_mask_reg[tgtBank] = regWrData[0];
							IDX_FAULT_MASK_REG: nxt_state.fault_mask_reg[tgtBank] = regWrData[0];
							IDX_BASE_PRIORITY_MASK_REG:   nxt_state.base_priority_mask_reg[tgtBank] = regWrData[7:0];
							IDX_CONTROL:   nxt_state.control[tgtBank] = regWrData[1:0];
							IDX_MAIN_STACK_LIMIT:    nxt_state.main_stack_limit[tgtBank] = regWrData[31:3];
							IDX_PROCESS_STACK_LIMIT:    nxt_state.process_stack_limit[tgtBank] = regWrData[31:3];
							default:       nxt_state.accessFault = 1'b1;
						endcase
					end
				end
				// A push outranks a port write to the same stack pointer.
				if (pushReq) begin
					if (pushSp < activeLim) begin
						nxt_state.stackFault = 1'b1;
					end else begin
						if (useProc) begin
							nxt_state.process_stack_ptr[curBank] = pushSp;
						end else begin
							nxt_state.main_stack_ptr[curBank] = pushSp;
						end
						nxt_state.memWr   = 1'b1;
						nxt_state.memAddr = pushSp;
						nxt_state.memData = pushItem;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cur_ff          <= '0;
			cur_ff.lr       <= LR_RST;
			cur_ff.vecFetch <= 1'b1;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign vecFetch    = cur_ff.vecFetch;
	assign regRdData   = cur_ff.rdData;
	assign memWr       = cur_ff.memWr;
	assign memAddr     = cur_ff.memAddr;
	assign memData     = cur_ff.memData;
	assign stackFault  = cur_ff.stackFault;
	assign accessFault = cur_ff.accessFault;
	assign thumbBit    = cur_ff.tBit;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence vecTaken_s;
		cur_ff.phase == PH_FETCH && vecValid;
	endsequence

	sequence pushTaken_s;
		cur_ff.phase == PH_RUN && pushReq && pushSp >= activeLim;
	endsequence

	reset_vector_load_a: assert property (
		vecTaken_s |=> cur_ff.main_stack_ptr[BANK_S] == $past(vecSp)
			&& cur_ff.pc == {$past(vecPc[31:1]), 1'b0} && !vecFetch)
		else $error("Reset vector not loaded into main pointer and counter.");

	thumb_bit_load_a: assert property (
		vecTaken_s |=> thumbBit == $past(vecPc[0]) && cur_ff.application_flag_field == '0)
		else $error("Thumb bit not taken from vector bit zero.");

	push_decrement_a: assert property (
		pushTaken_s |=> memWr && memAddr == $past(activeSp) - PUSH_STEP)
		else $error("Push did not write at the decremented pointer.");

	full_descending_a: assert property (
		pushTaken_s ##1 (!pushReq && !regWr && $stable(secureIn) && $stable(cur_ff.interrupt_status_field)
			&& $stable(cur_ff.control)) |-> activeSp == memAddr)
		else $error("Stack pointer does not address the last pushed item.");

	handler_main_sp_a: assert property (
		handler |-> activeSp == cur_ff.main_stack_ptr[curBank])
		else $error("Handler mode not using the main stack pointer.");

	thread_select_a: assert property (
		(!handler && cur_ff.control[curBank][CTRL_STACK_SELECT_BIT]) |-> activeSp == cur_ff.process_stack_ptr[curBank])
		else $error("Thread mode select bit ignored.");

	limit_fault_a: assert property (
		(cur_ff.phase == PH_RUN && pushReq && pushSp < activeLim)
			|=> stackFault && !memWr ##1 (!stackFault || $past(pushReq) || $past(regWr)))
		else $error("Push below limit was not refused.");

	priv_denied_a: assert property (
		(cur_ff.phase == PH_RUN && regRd && !privileged && regAddr == IDX_BASE_PRIORITY_MASK_REG)
			|=> accessFault && regRdData == '0)
		else $error("Unprivileged read of a mask register was not refused.");

	limit_low_zero_a: assert property (
		(cur_ff.phase == PH_RUN && regRd && !denied && baseIdx == IDX_MAIN_STACK_LIMIT)
			|=> regRdData[2:0] == 3'h0)
		else $error("Limit register low bits not zero.");

	status_readonly_a: assert property (
		(cur_ff.phase == PH_RUN && regWr && regAddr == IDX_INTERRUPT_STATUS_FIELD) |=> accessFault)
		else $error("Write to interrupt status field not refused.");

	link_reset_a: assert property (
		$rose(rst_b) |-> cur_ff.lr == LR_RST && cur_ff.phase == PH_FETCH)
		else $error("Link register not all ones after reset.");

	mask_reset_a: assert property (
		$rose(rst_b) |-> cur_ff.priority_mask_reg == '0 && cur_ff.fault_mask_reg == '0
			&& cur_ff.base_priority_mask_reg == '0 && cur_ff.control == '0
			&& cur_ff.main_stack_limit == '0 && cur_ff.process_stack_limit == '0)
		else $error("Mask, control or limit register not zero after reset.");

	gpr_write_a: assert property (
		(cur_ff.phase == PH_RUN && regWr && regAddr < IDX_SP)
			|=> cur_ff.gpr[$past(regAddr[3:0])] == $past(regWrData))
		else $error("Data register write not stored.");

	application_flag_field_write_a: assert property (
		(cur_ff.phase == PH_RUN && regWr && regAddr == IDX_APPLICATION_FLAG_FIELD)
			|=> cur_ff.application_flag_field == ($past(regWrData) & APPLICATION_FLAG_FIELD_MASK))
		else $error("Application flag write not stored.");

	limit_write_a: assert property (
		(cur_ff.phase == PH_RUN && regWr && !denied && baseIdx == IDX_MAIN_STACK_LIMIT)
			|=> cur_ff.main_stack_limit[$past(tgtBank)] == $past(regWrData[31:3]))
		else $error("Main stack limit write not stored.");

	alias_denied_a: assert property (
		(cur_ff.phase == PH_RUN && (regRd || regWr) && nsAlias && !secureIn) |=> accessFault)
		else $error("Non-secure bank reached from non-secure state.");

	thread_main_a: assert property (
		(!handler && !cur_ff.control[curBank][CTRL_STACK_SELECT_BIT])
			|-> activeSp == cur_ff.main_stack_ptr[curBank])
		else $error("Thread mode main pointer not used.");
endmodule : core_register_stack_select
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench for the core register stack with banked stack pointers.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import core_regs_pkg::*;
;
	localparam logic [31:0] SPV = 32'h20000100;
	localparam logic [31:0] PCV = 32'h00000201;

	logic              clk_sys;
	logic              rst_b;
	logic              secureIn;
	logic [INTERRUPT_STATUS_FIELD_W-1:0] excNum;
	logic              vecValid;
	logic [DATA_W-1:0] vecSp;
	logic [DATA_W-1:0] vecPc;
	logic              vecFetch;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic              regWr;
	logic              regRd;
	logic [DATA_W-1:0] regRdData;
	logic [DATA_W-1:0] regRdData2;
	logic              pushReq;
	logic [DATA_W-1:0] pushItem;
	logic              memWr;
	logic [DATA_W-1:0] memAddr;
	logic [DATA_W-1:0] memData;
	logic              stackFault;
	logic              accessFault;
	logic              thumbBit;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] d2;
	logic              af;
	logic              sf;
	int                n_mismatch;
	int                n_compared;

	core_register_stack_select #(.SEC_EXT(1'b1)) u_core_register_stack_select (
		.clk_sys(clk_sys), .rst_b(rst_b), .secureIn(secureIn), .excNum(excNum),
		.vecValid(vecValid), .vecSp(vecSp), .vecPc(vecPc), .vecFetch(vecFetch),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .pushReq(pushReq), .pushItem(pushItem), .memWr(memWr),
		.memAddr(memAddr), .memData(memData), .stackFault(stackFault),
		.accessFault(accessFault), .thumbBit(thumbBit)
	);

	// Second copy built without the security extension, fed the same stimulus.
	core_register_stack_select #(.SEC_EXT(1'b0)) u_core_register_stack_select_ne (
		.clk_sys(clk_sys), .rst_b(rst_b), .secureIn(secureIn), .excNum(excNum),
		.vecValid(vecValid), .vecSp(vecSp), .vecPc(vecPc), .vecFetch(),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData2), .pushReq(pushReq), .pushItem(pushItem), .memWr(),
		.memAddr(), .memData(), .stackFault(), .accessFault(), .thumbBit()
	);

	always #10 clk_sys = ~clk_sys;

	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk_sys);
		regRd   <= 1'b0;
		#1;
		d  = regRdData;
		d2 = regRdData2;
		af = accessFault;
	endtask : rd

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		regAddr   <= a;
		regWrData <= v;
		regWr     <= 1'b1;
		@(posedge clk_sys);
		regWr     <= 1'b0;
		#1;
		af = accessFault;
		sf = stackFault;
	endtask : wr

	task automatic push(input logic [31:0] v);
		@(posedge clk_sys);
		pushReq  <= 1'b1;
		pushItem <= v;
		@(posedge clk_sys);
		pushReq  <= 1'b0;
		#1;
		sf = stackFault;
	endtask : push

	// Handler mode follows the exception number one cycle late, so settle first.
	task automatic ctx(input logic s, input logic [INTERRUPT_STATUS_FIELD_W-1:0] e);
		@(posedge clk_sys);
		secureIn <= s;
		excNum   <= e;
		repeat (2) @(posedge clk_sys);
	endtask : ctx

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		stop_test();
	end

	initial begin
		clk_sys = 1'b0;
		rst_b = 1'b0;
		secureIn = 1'b1;
		excNum = '0;
		vecValid = 1'b0;
		vecSp = SPV;
		vecPc = PCV;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		pushReq = 1'b0;
		pushItem = '0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk("vecFetch", 32'(vecFetch), 32'h1);
		@(posedge clk_sys);
		vecValid <= 1'b1;
		@(posedge clk_sys);
		vecValid <= 1'b0;
		#1;
		chk("vecFetch", 32'(vecFetch), 32'h0);
		chk("thumbBit", 32'(thumbBit), 32'h1);
		rd(IDX_SP);
		chk("sp", d, SPV);
		chk("sp ne", d2, SPV);
		rd(IDX_PC);
		chk("pc", d, 32'h00000200);
		rd(IDX_LR);
		chk("lr ne", d2, LR_RST);
		rd(IDX_COMBINED_STATUS_WORD);
		chk("combined_status_word", d, 32'h00000000);
		rd(IDX_EXECUTION_STATUS_FIELD);
		chk("execution_status_field", d, 32'h00000000);
		rd(IDX_INTERRUPT_STATUS_FIELD);
		chk("interrupt_status_field", d, 32'h00000000);
		for (int i = 0; i < 6; i++) begin
			rd(IDX_PRIORITY_MASK_REG + 6'(i));
			chk("mask s", d, 32'h00000000);
			rd(IDX_PRIORITY_MASK_REG + 6'(i) + 6'h20);
			chk("mask ns", d, 32'h00000000);
		end
		for (int i = 0; i < 13; i++)
			wr(6'(i), 32'hA5A50000 + 32'(i));
		for (int i = 0; i < 13; i++) begin
			rd(6'(i));
			chk("gpr", d, 32'hA5A50000 + 32'(i));
		end
		wr(IDX_APPLICATION_FLAG_FIELD, 32'hFFFFFFFF);
		rd(IDX_APPLICATION_FLAG_FIELD);
		chk("application_flag_field", d, 32'hF80F0000);
		wr(IDX_INTERRUPT_STATUS_FIELD, 32'h00000001);
		chk("interrupt_status_field wr", 32'(af), 32'h1);
		wr(IDX_EXECUTION_STATUS_FIELD, 32'h01000000);
		chk("execution_status_field wr", 32'(af), 32'h1);
		wr(IDX_PSP, 32'h20000800);
		wr(IDX_CONTROL, 32'h00000002);
		rd(IDX_SP);
		chk("sp s thr", d, 32'h20000800);
		chk("sp ne thr", d2, 32'h20000800);
		ctx(1'b1, 9'h003);
		rd(IDX_SP);
		chk("sp s hnd", d, SPV);
		chk("sp ne hnd", d2, SPV);
		rd(IDX_INTERRUPT_STATUS_FIELD);
		chk("interrupt_status_field exc", d, 32'h00000003);
		ctx(1'b1, 9'h000);
		wr(IDX_CONTROL, 32'h00000000);
		wr(IDX_MSP + 6'h20, 32'h30000400);
		wr(IDX_PSP + 6'h20, 32'h30000800);
		wr(IDX_CONTROL + 6'h20, 32'h00000002);
		wr(IDX_PRIORITY_MASK_REG + 6'h20, 32'h00000001);
		ctx(1'b0, 9'h000);
		rd(IDX_SP);
		chk("sp ns thr", d, 32'h30000800);
		rd(IDX_PRIORITY_MASK_REG);
		chk("priority_mask_reg ns", d, 32'h00000001);
		rd(IDX_MSP + 6'h20);
		chk("ns alias", 32'(af), 32'h1);
		ctx(1'b0, 9'h005);
		rd(IDX_SP);
		chk("sp ns hnd", d, 32'h30000400);
		ctx(1'b1, 9'h000);
		rd(IDX_PRIORITY_MASK_REG);
		chk("priority_mask_reg s", d, 32'h00000000);
		rd(IDX_SP);
		chk("sp s back", d, SPV);
		wr(IDX_MAIN_STACK_LIMIT, 32'h200000FF);
		rd(IDX_MAIN_STACK_LIMIT);
		chk("limit", d, 32'h200000F8);
		push(32'h00000011);
		chk("memWr", 32'(memWr), 32'h1);
		chk("memAddr", memAddr, SPV - 32'h4);
		chk("memData", memData, 32'h00000011);
		rd(IDX_SP);
		chk("sp push", d, SPV - 32'h4);
		push(32'h00000022);
		chk("memAddr", memAddr, SPV - 32'h8);
		push(32'h00000033);
		chk("push flt", 32'(sf), 32'h1);
		chk("memWr", 32'(memWr), 32'h0);
		rd(IDX_SP);
		chk("sp kept", d, SPV - 32'h8);
		wr(IDX_SP, SPV - 32'h10);
		chk("sp wr flt", 32'(sf), 32'h1);
		wr(IDX_CONTROL, 32'h00000001);
		wr(IDX_PRIORITY_MASK_REG, 32'h00000001);
		chk("unpriv", 32'(af), 32'h1);
		rd(IDX_BASE_PRIORITY_MASK_REG);
		chk("unpriv rd", 32'(af), 32'h1);
		chk("unpriv data", d, 32'h00000000);
		wr(6'h00, 32'h00000005);
		chk("unpriv gpr", 32'(af), 32'h0);
		rd(IDX_APPLICATION_FLAG_FIELD);
		chk("unpriv application_flag_field", 32'(af), 32'h0);
		ctx(1'b1, 9'h003);
		wr(IDX_CONTROL, 32'h00000000);
		chk("hnd priv", 32'(af), 32'h0);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
